// ==== hw/rtcbuf_core.sv ====
// timekeeping counters, buffer/transfer registers and supply watch of the serial clock
// assumes a serial slave on clk that gives transfer start/stop pulses and byte strobes
`timescale 1ns/10ps
`include "rtcbuf_params.svh"

// How it works
// - time base is 32.768 kHz crystal divided down
// - eight BCD clock bytes, fractions through year
// - halt bit stops oscillator, clearing restarts it
// - century bits at bits 6 and 7 of 03h
// - weekday at 04h, date month year 05h-07h
// - oscillator failure sets fail flag, 0fh bit 2
// - 09h bit 7 enables fail interrupt output
// - clock byte write loads counters, resets divider
// - transfer start copies counters into buffers
// - written transfer loads all buffers into counters
// - writes above 07h leave counters untouched
// - 32 addresses, BCD clock, binary others
// - capture moves all bits at once, load only the writable bits
// - reset pin low, held recovery time after
// - recovery affects only reset pin
// - below threshold, ignore inputs, block writes
// - below switchover, keep counters and memory
// - backup entry sets freeze, blocks capture
// - pointer past 07h also loads counters
module rtcbuf_core
#(
    parameter int REC_CYCLES = `RTCBUF_REC_TIME_MS * (`RTCBUF_CLK_HZ / 1000),
    parameter int FAIL_CYCLES = `RTCBUF_FAIL_TIME_US * (`RTCBUF_CLK_HZ / 1000000)
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic osc_in,
    input wire logic below_reset_threshold,
    input wire logic below_switchover_threshold,
    input wire logic xfer_start,
    input wire logic xfer_stop,
    input wire logic ptr_past_clock,
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    input wire logic [4:0] rd_addr,
    output logic [7:0] rd_data_q,
    output logic osc_fail_irq_n_q,
    output logic rst_pin_o_q,
    output logic rst_pin_oe_q
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    localparam int REC_W = $clog2(REC_CYCLES + 1);
    localparam int FAIL_W = $clog2(FAIL_CYCLES + 1);

    logic [2:0] osc_sync_q;
    logic [1:0] low_sync_q;
    logic [2:0] so_sync_q;
    logic osc_edge;
    logic vcc_low;
    logic so_enter;
    logic [`RTCBUF_ACC_W-1:0] acc_q;
    logic [`RTCBUF_ACC_W:0] acc_sum;
    logic tick;
    rtcbuf_pkg::rtcbuf_time_type time_q;
    rtcbuf_pkg::rtcbuf_time_type time_d;
    rtcbuf_pkg::rtcbuf_time_type buf_q;
    logic dirty_q;
    logic load_pend_q;
    logic do_load;
    logic halt;
    logic freeze_q;
    logic osc_fail_q;
    logic [FAIL_W-1:0] fail_cnt_q;
    logic [7:0] mem_q [31:8];
    logic bus_start;
    logic bus_stop;
    logic bus_wr;
    logic bus_rd;
    logic bus_past;
    logic wr_clock;
    rtcbuf_pkg::rtcbuf_pwr_type pwr_q;
    logic [REC_W-1:0] rec_cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // one BCD step: wraps to first after top, msb of result flags the wrap
    function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] top, input logic [7:0] first);
        logic [8:0] r;
        r = {1'b0, v};
        if (v >= top)
        begin
            r = {1'b1, first};
        end
        else if (v[3:0] == 4'h9)
        begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end
        else
        begin
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // last date of a BCD month, leap years every fourth year
    function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        logic [7:0] r;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            8'h02: r = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
            default: r = 8'h31;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // two flops ahead of any logic; a third flop feeds the edge detectors
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_sync_q <= 3'h0;
            low_sync_q <= 2'h3;
            so_sync_q <= 3'h7;
        end
        else
        begin
            osc_sync_q <= {osc_sync_q[1:0], osc_in};
            low_sync_q <= {low_sync_q[0], below_reset_threshold};
            so_sync_q <= {so_sync_q[1:0], below_switchover_threshold};
        end
    end

    assign vcc_low = low_sync_q[1];
    assign so_enter = so_sync_q[1] && !so_sync_q[2];
    assign halt = time_q[8 + `RTCBUF_B_HALT];
    assign osc_edge = osc_sync_q[1] && !osc_sync_q[2] && !halt;

    // bus strobes are dropped while supply is under the reset threshold
    assign bus_start = xfer_start && !vcc_low;
    assign bus_stop = xfer_stop && !vcc_low;
    assign bus_wr = wr_en && !vcc_low;
    assign bus_rd = rd_en && !vcc_low;
    assign bus_past = ptr_past_clock && !vcc_low;
    assign wr_clock = bus_wr && (wr_addr <= `RTCBUF_A_YEAR);

    ////////////////////////////////////////////////////////////////////////////
    // divider: adds 100 per crystal edge, a wrap of 32768 is one hundredth

    assign acc_sum = {1'b0, acc_q} + {1'b0, `RTCBUF_ACC_STEP};
    assign tick = osc_edge && acc_sum[`RTCBUF_ACC_W - 1]; // carry past 32768 is one hundredth
    assign do_load = load_pend_q && !tick;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_q <= '0;
        end
        else if (do_load)
        begin
            acc_q <= '0;
        end
        else if (osc_edge)
        begin
            acc_q <= {1'b0, acc_sum[14:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next count: BCD carry chain from hundredths to century

    always_comb
    begin
        logic [8:0] s;
        logic c;
        s = '0;
        c = 1'b1;
        time_d = time_q;
        s = bcd_step(time_q[7:0], 8'h99, 8'h00);
        time_d[7:0] = s[7:0];
        c = s[8];
        if (c)
        begin
            s = bcd_step({1'b0, time_q[14:8]}, 8'h59, 8'h00);
            time_d[14:8] = s[6:0];
            c = s[8];
        end
        if (c)
        begin
            s = bcd_step(time_q[23:16], 8'h59, 8'h00);
            time_d[23:16] = s[7:0];
            c = s[8];
        end
        if (c)
        begin
            s = bcd_step({2'b00, time_q[29:24]}, 8'h23, 8'h00);
            time_d[29:24] = s[5:0];
            c = s[8];
        end
        if (c)
        begin
            s = bcd_step(time_q[39:32], 8'h07, 8'h01);
            time_d[39:32] = s[7:0];
            s = bcd_step(time_q[47:40], month_end(time_q[55:48], time_q[63:56]), 8'h01);
            time_d[47:40] = s[7:0];
            c = s[8];
        end
        if (c)
        begin
            s = bcd_step(time_q[55:48], 8'h12, 8'h01);
            time_d[55:48] = s[7:0];
            c = s[8];
        end
        if (c)
        begin
            s = bcd_step(time_q[63:56], 8'h99, 8'h00);
            time_d[63:56] = s[7:0];
            c = s[8];
        end
        if (c)
        begin
            time_d[31:30] = time_q[31:30] + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counters: kept through backup, loaded whole from the buffers

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            time_q <= `RTCBUF_TIME_RST;
        end
        else if (do_load)
        begin
            time_q <= buf_q & `RTCBUF_MASK_TIME;
        end
        else if (tick)
        begin
            time_q <= time_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // buffer/transfer registers and load request

    // capture at each transfer start unless frozen, byte writes land here
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_q <= `RTCBUF_TIME_RST;
        end
        else if (bus_start && !freeze_q)
        begin
            buf_q <= time_q;
        end
        else if (wr_clock)
        begin
            buf_q[wr_addr[2:0]*8 +: 8] <= wr_data;
        end
    end

    // a clock byte write marks the transfer; stop or pointer wrap asks for a load
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dirty_q <= 1'b0;
            load_pend_q <= 1'b0;
        end
        else
        begin
            if (vcc_low)
            begin
                dirty_q <= 1'b0;
            end
            else if (bus_start)
            begin
                dirty_q <= wr_clock;
            end
            else if ((bus_stop || bus_past) && (dirty_q || wr_clock))
            begin
                dirty_q <= 1'b0;
            end
            else if (wr_clock)
            begin
                dirty_q <= 1'b1;
            end
            if ((bus_stop || bus_past) && (dirty_q || wr_clock))
            begin
                load_pend_q <= 1'b1;
            end
            else if (do_load)
            begin
                load_pend_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // plain registers 08h to 1Fh, binary or BCD as the host writes them

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 8; i < 32; i++)
            begin
                mem_q[i] <= 8'h00;
            end
        end
        else if (bus_wr && !wr_clock)
        begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // freeze bit: set on backup entry, host clears it; the set wins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            freeze_q <= 1'b0;
        end
        else if (so_enter)
        begin
            freeze_q <= 1'b1;
        end
        else if (bus_wr && wr_addr == `RTCBUF_A_FREEZE)
        begin
            freeze_q <= wr_data[`RTCBUF_B_FREEZE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator fail detect: no crystal edge for the fail time while running

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fail_cnt_q <= '0;
            osc_fail_q <= 1'b0;
        end
        else
        begin
            if (halt || osc_sync_q[1] != osc_sync_q[2])
            begin
                fail_cnt_q <= '0;
            end
            else if (fail_cnt_q != FAIL_W'(FAIL_CYCLES))
            begin
                fail_cnt_q <= fail_cnt_q + 1'b1;
            end
            if (fail_cnt_q == FAIL_W'(FAIL_CYCLES))
            begin
                osc_fail_q <= 1'b1;
            end
            else if (bus_wr && wr_addr == `RTCBUF_A_FLAGS && !wr_data[`RTCBUF_B_OF])
            begin
                osc_fail_q <= 1'b0;
            end
        end
    end

    // interrupt pin, low while the flag is set and enabled
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_fail_irq_n_q <= 1'b1;
        end
        else
        begin
            osc_fail_irq_n_q <= !(osc_fail_q && mem_q[`RTCBUF_A_WDOG][`RTCBUF_B_OSC_FAIL_IRQ_ENABLE]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: clock bytes from the buffers, status merged into its bytes

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_q <= 8'h00;
        end
        else if (bus_rd)
        begin
            if (rd_addr <= `RTCBUF_A_YEAR)
            begin
                rd_data_q <= buf_q[rd_addr[2:0]*8 +: 8];
            end
            else if (rd_addr == `RTCBUF_A_FREEZE)
            begin
                rd_data_q <= {mem_q[rd_addr][7], freeze_q, mem_q[rd_addr][5:0]};
            end
            else if (rd_addr == `RTCBUF_A_FLAGS)
            begin
                rd_data_q <= {mem_q[rd_addr][7:3], osc_fail_q, 2'b00};
            end
            else
            begin
                rd_data_q <= mem_q[rd_addr];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset pin: low under threshold and for the recovery time after

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_q <= rtcbuf_pkg::PWR_RECOVER;
            rec_cnt_q <= '0;
        end
        else
        begin
            case (pwr_q)
                rtcbuf_pkg::PWR_OK:
                begin
                    if (vcc_low)
                    begin
                        pwr_q <= rtcbuf_pkg::PWR_LOW;
                    end
                end
                rtcbuf_pkg::PWR_LOW:
                begin
                    rec_cnt_q <= '0;
                    if (!vcc_low)
                    begin
                        pwr_q <= rtcbuf_pkg::PWR_RECOVER;
                    end
                end
                rtcbuf_pkg::PWR_RECOVER:
                begin
                    if (vcc_low)
                    begin
                        pwr_q <= rtcbuf_pkg::PWR_LOW;
                    end
                    else if (rec_cnt_q == REC_W'(REC_CYCLES - 1))
                    begin
                        pwr_q <= rtcbuf_pkg::PWR_OK;
                    end
                    else
                    begin
                        rec_cnt_q <= rec_cnt_q + 1'b1;
                    end
                end
                default:
                begin
                    pwr_q <= rtcbuf_pkg::PWR_LOW;
                end
            endcase
        end
    end

    // open drain: only ever drives low
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_pin_o_q <= 1'b0;
            rst_pin_oe_q <= 1'b1;
        end
        else
        begin
            rst_pin_o_q <= 1'b0;
            rst_pin_oe_q <= (pwr_q != rtcbuf_pkg::PWR_OK) || vcc_low;
        end
    end

endmodule

// ==== hw/rtcbuf_params.svh ====
// constants for the timekeeping and buffer core of the serial clock
// assumes a 40 MHz system clock and a 32.768 kHz crystal square wave input
`ifndef RTCBUF_PARAMS_SVH
`define RTCBUF_PARAMS_SVH

// system clock rate and printed times
`define RTCBUF_CLK_HZ 40000000
`define RTCBUF_OSC_HZ 32768
`define RTCBUF_REC_TIME_MS 210
`define RTCBUF_FAIL_TIME_US 1000

// crystal edges folded into hundredths of a second
`define RTCBUF_ACC_STEP 16'h0064
`define RTCBUF_ACC_W 16

// register addresses
`define RTCBUF_A_HUND 5'h00
`define RTCBUF_A_SEC 5'h01
`define RTCBUF_A_HOUR 5'h03
`define RTCBUF_A_DOW 5'h04
`define RTCBUF_A_YEAR 5'h07
`define RTCBUF_A_WDOG 5'h09
`define RTCBUF_A_FREEZE 5'h0C
`define RTCBUF_A_FLAGS 5'h0F
`define RTCBUF_A_TRIM 5'h12

// bit positions
`define RTCBUF_B_HALT 7
`define RTCBUF_B_CB0 6
`define RTCBUF_B_CB1 7
`define RTCBUF_B_OSC_FAIL_IRQ_ENABLE 7
`define RTCBUF_B_FREEZE 6
`define RTCBUF_B_OF 2

// writable bits of each clock byte
`define RTCBUF_MASK_TIME 64'hFF1F_3F07_FF7F_FFFF

// reset value of the counters: 00:00:00.00, day 1, 01/01/00
`define RTCBUF_TIME_RST 64'h0001_0101_0000_0000
`endif

// ==== hw/rtcbuf_pkg.sv ====
// types shared by the timekeeping and buffer core
// assumes nothing beyond the constants header
package rtcbuf_pkg;
    typedef logic [7:0] rtcbuf_byte_type;
    typedef logic [63:0] rtcbuf_time_type;
    typedef enum logic [1:0] {PWR_OK, PWR_LOW, PWR_RECOVER} rtcbuf_pwr_type;
endpackage

// ==== verification/rtcbuf_core_bench.sv ====
// self-checking bench for the timekeeping and buffer core
// assumes the host model drives the register port, the bench the pins
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module rtcbuf_core_bench;
    localparam int REC = 20;
    localparam int FAIL = 50;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic osc_in = 1'b0;
    logic osc_run = 1'b1;
    logic blo_rst = 1'b0;
    logic blo_sw = 1'b0;
    logic [3:0] osc_cnt = 4'h0;
    logic xfer_start, xfer_stop, ptr_past_clock, wr_en, rd_en, irq_n, pin_o, pin_oe;
    logic [4:0] wr_addr, rd_addr;
    logic [7:0] wr_data, rd_data_q;
    logic [7:0] exp_t [0:7];
    logic [31:0] rng_q = 32'h6145_123a;
    int mismatches = 0;
    int n_checks = 0;
    ////////////////////////////////////////
    // clock and crystal stand-in, a crystal rising edge every 8 clocks
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        osc_cnt <= osc_cnt + 4'h1;
        if (osc_run && osc_cnt[1:0] == 2'b11)
            osc_in <= ~osc_in;
    end
    rtcbuf_core #(.REC_CYCLES(REC), .FAIL_CYCLES(FAIL)) rtcbuf_core_i
    (
        .clk(clk), .rst_n(rst_n), .osc_in(osc_in),
        .below_reset_threshold(blo_rst), .below_switchover_threshold(blo_sw),
        .xfer_start(xfer_start), .xfer_stop(xfer_stop), .ptr_past_clock(ptr_past_clock),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data_q(rd_data_q), .osc_fail_irq_n_q(irq_n), .rst_pin_o_q(pin_o), .rst_pin_oe_q(pin_oe)
    );
    rtcbuf_host_model rtcbuf_host_model_i
    (
        .clk(clk), .rd_data_q(rd_data_q), .xfer_start(xfer_start), .xfer_stop(xfer_stop),
        .ptr_past_clock(ptr_past_clock), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr)
    );
    ////////////////////////////////////////
    // xorshift source and bcd helper
    function automatic logic [31:0] rnd();
        rng_q = rng_q ^ (rng_q << 13);
        rng_q = rng_q ^ (rng_q >> 17);
        rng_q = rng_q ^ (rng_q << 5);
        return rng_q;
    endfunction
    function automatic logic [7:0] bcd(input int n);
        return 8'((n / 10) * 16 + n % 10);
    endfunction
    // single byte writes and reads, each its own transfer
    task automatic put(input logic [4:0] a, input logic [7:0] d);
        rtcbuf_host_model_i.wbuf[a] = d;
        rtcbuf_host_model_i.run(a, 1, 1'b1);
    endtask
    task automatic get(input logic [4:0] a, output logic [7:0] d);
        rtcbuf_host_model_i.run(a, 1, 1'b0);
        d = rtcbuf_host_model_i.rbuf[a];
    endtask
    // whole clock set written, or read back and compared, in one transfer
    task automatic write_time();
        for (int i = 0; i < 8; i++)
            rtcbuf_host_model_i.wbuf[i] = exp_t[i];
        rtcbuf_host_model_i.run(5'h00, 8, 1'b1);
    endtask
    task automatic check_time();
        rtcbuf_host_model_i.run(5'h00, 8, 1'b0);
        for (int i = 0; i < 8; i++)
            `CHK("clock_byte", exp_t[i], rtcbuf_host_model_i.rbuf[i])
    endtask
    // bounded wait for the reset pin to settle
    task automatic wait_oe(input logic v, output int c);
        c = 0;
        while (pin_oe !== v && c < REC + 40)
        begin
            @(posedge clk);
            c++;
        end
        `CHK("reset_pin", v, pin_oe)
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [7:0] d;
        logic [7:0] r;
        int c;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wait_oe(1'b0, c);
        `CHK("recovery_len", 1'b1, c >= REC)
        $display("test reset done");
        put(5'h01, 8'h80);
        put(5'h01, 8'h00);
        repeat (3)
        begin
            exp_t = '{bcd(int'(rnd() % 100)), bcd(int'(rnd() % 60)), bcd(int'(rnd() % 60)),
                bcd(int'(rnd() % 24)) | 8'(rnd() << 6), bcd(int'(1 + rnd() % 7)),
                bcd(int'(1 + rnd() % 28)), bcd(int'(1 + rnd() % 12)), bcd(int'(rnd() % 100))};
            write_time();
            check_time();
        end
        d = bcd(int'(rnd() % 60));
        exp_t[2] = d;
        put(5'h02, d);
        check_time();
        r = 8'(rnd());
        put(5'h12, r);
        get(5'h12, d);
        `CHK("trim", r, d)
        check_time();
        $display("test buffer load done");
        exp_t = '{8'h99, 8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
        write_time();
        repeat (3000) @(posedge clk);
        exp_t = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h01, 8'h01, 8'h01, 8'h00};
        check_time();
        $display("test rollover done");
        put(5'h01, 8'h80);
        exp_t[1] = 8'h80;
        repeat (3000) @(posedge clk);
        check_time();
        put(5'h01, 8'h00);
        repeat (3000) @(posedge clk);
        exp_t[0] = 8'h01;
        exp_t[1] = 8'h00;
        check_time();
        $display("test halt done");
        put(5'h09, 8'h80);
        osc_run <= 1'b0;
        repeat (FAIL + 20) @(posedge clk);
        get(5'h0F, d);
        `CHK("fail_flag", 1'b1, d[2])
        `CHK("fail_irq", 1'b0, irq_n)
        put(5'h09, 8'h00);
        `CHK("irq_masked", 1'b1, irq_n)
        osc_run <= 1'b1;
        repeat (20) @(posedge clk);
        put(5'h0F, 8'h04);
        get(5'h0F, d);
        `CHK("fail_keep", 1'b1, d[2])
        put(5'h0F, 8'h00);
        get(5'h0F, d);
        `CHK("fail_clear", 1'b0, d[2])
        put(5'h09, 8'h80);
        `CHK("irq_idle", 1'b1, irq_n)
        $display("test osc fail done");
        exp_t = '{8'h00, 8'h30, 8'h15, 8'h08, 8'h03, 8'h14, 8'h06, 8'h25};
        write_time();
        blo_sw <= 1'b1;
        repeat (3000) @(posedge clk);
        get(5'h0C, d);
        `CHK("freeze_set", 1'b1, d[6])
        check_time();
        blo_sw <= 1'b0;
        put(5'h0C, 8'h00);
        get(5'h0C, d);
        `CHK("freeze_clear", 1'b0, d[6])
        exp_t[0] = 8'h01;
        check_time();
        $display("test freeze done");
        blo_rst <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("pin_low", 1'b1, pin_oe)
        put(5'h12, ~r);
        blo_rst <= 1'b0;
        repeat (3) @(posedge clk);
        get(5'h12, d);
        `CHK("write_blocked", r, d)
        `CHK("pin_recovering", 1'b1, pin_oe)
        wait_oe(1'b0, c);
        $display("test supply done");
        report_and_stop();
    end
    // watchdog for a hung run
    initial
    begin
        repeat (40000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule

// ==== verification/rtcbuf_core_properties.sv ====
// port checker for the timekeeping and buffer core
// assumes binding to every rtcbuf_core instance, one clock domain
`timescale 1ns/10ps
module rtcbuf_core_properties
#(
    parameter int REC_CYCLES = 20,
    parameter int FAIL_CYCLES = 50
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic osc_in,
    input wire logic below_reset_threshold,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [4:0] rd_addr,
    input wire logic [7:0] rd_data_q,
    input wire logic osc_fail_irq_n_q,
    input wire logic rst_pin_o_q,
    input wire logic rst_pin_oe_q
);
    logic [31:0] rec_cnt_q;
    logic [31:0] idle_cnt_q;
    logic rd_ok;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // cycles with supply good while the reset pin is still driven
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            rec_cnt_q <= '0;
        else if (rst_pin_oe_q && !below_reset_threshold)
            rec_cnt_q <= rec_cnt_q + 32'h0000_0001;
        else
            rec_cnt_q <= '0;
    // cycles since the crystal input last changed
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            idle_cnt_q <= '0;
        else if ($changed(osc_in))
            idle_cnt_q <= '0;
        else
            idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
    // a read strobe that the supply watch lets through
    assign rd_ok = rd_en && !below_reset_threshold;
    ////////////////////////////////////////
    pin_data_low_a: assert property (rst_pin_o_q == 1'b0)
        else $error("reset pin data not low");
    reset_hold_a: assert property ($rose(rst_n) |-> rst_pin_oe_q [*4])
        else $error("reset pin released too early after reset");
    pin_assert_a: assert property (below_reset_threshold [*5] |-> rst_pin_oe_q)
        else $error("reset pin not driven on low supply");
    recovery_hold_a: assert property ($fell(below_reset_threshold) |-> rst_pin_oe_q [*8])
        else $error("recovery wait cut short");
    recovery_end_a: assert property (rec_cnt_q <= REC_CYCLES + 8)
        else $error("reset pin held past the recovery time");
    irq_set_cause_a: assert property ($fell(osc_fail_irq_n_q) |->
        idle_cnt_q >= FAIL_CYCLES || $past(wr_en) || $past(wr_en, 2) || $past(wr_en, 3))
        else $error("fail interrupt without a stalled crystal");
    irq_clear_cause_a: assert property ($rose(osc_fail_irq_n_q) |->
        $past(wr_en) || $past(wr_en, 2) || $past(wr_en, 3))
        else $error("fail interrupt released without a write");
    read_hold_a: assert property (!rd_en |=> $stable(rd_data_q))
        else $error("read data moved without a read");
    flags_low_a: assert property (rd_ok && rd_addr == 5'h0F && !$past(below_reset_threshold, 2)
        |=> rd_data_q[1:0] == 2'b00) else $error("flag byte low bits not zero");
    weekday_bits_a: assert property (rd_ok && rd_addr == 5'h04 && !$past(below_reset_threshold, 2)
        |=> rd_data_q[7:3] == 5'h00) else $error("weekday upper bits not zero");
    minute_bit_a: assert property (rd_ok && rd_addr == 5'h02 && !$past(below_reset_threshold, 2)
        |=> rd_data_q[7] == 1'b0) else $error("minute top bit not zero");
endmodule

bind rtcbuf_core rtcbuf_core_properties #(.REC_CYCLES(REC_CYCLES), .FAIL_CYCLES(FAIL_CYCLES)) rtcbuf_core_properties_i
(
    .clk(clk),
    .rst_n(rst_n),
    .osc_in(osc_in),
    .below_reset_threshold(below_reset_threshold),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data_q(rd_data_q),
    .osc_fail_irq_n_q(osc_fail_irq_n_q),
    .rst_pin_o_q(rst_pin_o_q),
    .rst_pin_oe_q(rst_pin_oe_q)
);

// ==== verification/rtcbuf_host_model.sv ====
// serial host stand-in: turns whole transfers into start, byte strobes and stop
// assumes the bench fills wbuf and reads rbuf by hierarchical reference
`timescale 1ns/10ps
module rtcbuf_host_model
(
    input wire logic clk,
    input wire logic [7:0] rd_data_q,
    output logic xfer_start,
    output logic xfer_stop,
    output logic ptr_past_clock,
    output logic wr_en,
    output logic [4:0] wr_addr,
    output logic [7:0] wr_data,
    output logic rd_en,
    output logic [4:0] rd_addr
);
    logic [7:0] wbuf [0:31];
    logic [7:0] rbuf [0:31];
    ////////////////////////////////////////
    // idle bus at time zero
    initial
    begin
        {xfer_start, xfer_stop, ptr_past_clock, wr_en, rd_en} = 5'h00;
        {wr_addr, rd_addr, wr_data} = 18'h0_0000;
    end
    // one transfer of n bytes from a0 upward, all bytes inside one start/stop
    task automatic run(input logic [4:0] a0, input int n, input logic wr);
        logic [4:0] a;
        a = a0;
        @(posedge clk);
        xfer_start <= 1'b1;
        repeat (n)
        begin
            @(posedge clk);
            xfer_start <= 1'b0;
            wr_en <= wr;
            rd_en <= !wr;
            wr_addr <= a;
            rd_addr <= a;
            wr_data <= wbuf[a];
            @(posedge clk);
            wr_en <= 1'b0;
            rd_en <= 1'b0;
            wr_addr <= ~a; // released lines show the inverse
            rd_addr <= ~a;
            wr_data <= ~wbuf[a];
            ptr_past_clock <= (a == 5'h07);
            @(posedge clk);
            ptr_past_clock <= 1'b0;
            if (!wr)
                rbuf[a] = rd_data_q;
            a = a + 5'h01;
        end
        @(posedge clk);
        xfer_stop <= 1'b1;
        @(posedge clk);
        xfer_stop <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule
